// ==== dma_chan_status.v ====
// How it works
// - Eight writable interrupt enables in bits 23..16, one enables.
// - Source done flag sets when source pointer equals source size.
// - Source half flag sets when source pointer reaches half size.
// - Destination done flag sets when destination pointer equals its size.
// - Destination half flag sets at half the destination size.
// - Block done sets after larger size moved, or on pattern match.
// - Cell done sets each time a full cell has moved.
// - Abort flag sets when selected abort source aborts the transfer.
// - Address error flag sets on bad source or destination address.
// - Interrupt control reads zero in bits 31..24 and 15..8.
// - Source size zero means 65536 bytes; upper bits read zero.
// - Destination size zero means 65536 bytes; upper bits read zero.
// - Read-only source pointer resets zero, cleared on pattern detect.
// - Cell size gives bytes per start event, zero means 65536.
// - Read-only destination pointer shows current byte index.
//
// Design decisions made here: the register offsets and the APB register port.
`timescale 1ns/100ps
`include "dma_chan_regs.vh"

module dma_chan_status #(
  parameter CNT_W   = 16,
  parameter NUM_IRQ = 256,
  parameter SEL_W   = 8
) (
  input  wire               sys_clk,
  input  wire               rst_n,
  // APB slave
  input  wire               psel,
  input  wire               penable,
  input  wire               pwrite,
  input  wire [7:0]         paddr,
  input  wire [31:0]        pwdata,
  output wire               pready,
  output reg  [31:0]        prdata,
  output reg                pslverr,
  // Transfer engine side
  input  wire               byte_stb,
  input  wire               pattern_hit,
  input  wire               src_addr_bad,
  input  wire               dst_addr_bad,
  input  wire               chan_active,
  input  wire [NUM_IRQ-1:0] irq_lines,
  output reg                xfer_abort,
  output reg  [31:0]        src_start,
  output reg  [31:0]        dst_start,
  output wire [CNT_W-1:0]   src_progress,
  output wire [CNT_W-1:0]   dst_progress,
  output wire [CNT_W-1:0]   cell_progress,
  output wire               chan_irq
);

  // Reset release through two flops, assertion stays asynchronous
  reg rst_meta_r;
  reg rst_sync_n;
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_r <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_n <= rst_meta_r;
    end
  end

  // Address decode shared by write and error paths
  function map_hit;
    input [7:0] a;
    begin
      case (a)
        `OFS_INT_CTRL, `OFS_SRC_START, `OFS_DST_START,
        `OFS_SRC_SIZE, `OFS_DST_SIZE, `OFS_SRC_PROG,
        `OFS_DST_PROG, `OFS_CELL_SIZE, `OFS_ABORT_CFG: map_hit = 1'b1;
        default: map_hit = 1'b0;
      endcase
    end
  endfunction

  // Configuration and status storage
  reg [7:0]       irq_en_r;
  reg [7:0]       flag_r;
  wire [7:0]      flag_nxt;
  reg [CNT_W-1:0] src_size_r;
  reg [CNT_W-1:0] dst_size_r;
  reg [CNT_W-1:0] cell_size_r;
  reg [SEL_W-1:0] abort_irq_select;
  reg             abort_src_en_r;

  // Zero wait states: read data is fetched in the setup cycle
  assign pready = 1'b1;

  // Unmapped writes fall out here, so they never reach storage
  wire setup_ph  = psel & ~penable;
  wire wr_commit = psel & penable & pready & pwrite & map_hit(paddr);
  wire int_wr    = wr_commit & (paddr == `OFS_INT_CTRL);

  // Zero means full 64K span, carried in one extra bit
  function [CNT_W:0] span_of;
    input [CNT_W-1:0] sz;
    begin
      span_of = {(sz == {CNT_W{1'b0}}), sz};
    end
  endfunction

  wire [CNT_W:0] src_span  = span_of(src_size_r);
  wire [CNT_W:0] dst_span  = span_of(dst_size_r);
  wire [CNT_W:0] cell_span = span_of(cell_size_r);
  wire [CNT_W:0] blk_span  = (src_span > dst_span) ? src_span : dst_span;

  wire src_done;
  wire src_half;
  wire dst_done;
  wire dst_half;
  wire cell_done;
  wire blk_done;

  // Abort only counts while the channel is actually moving data
  // selected source aborts
  wire abort_hit = abort_src_en_r & chan_active & irq_lines[abort_irq_select];

  // Block end and abort restart every pointer; pattern restarts source and cell
  wire clr_all = blk_done | abort_hit;
  wire clr_src = clr_all | pattern_hit;

  progress_counter #(.CNT_W(CNT_W)) u_src (
    .sys_clk (sys_clk),
    .rst_n   (rst_sync_n),
    .clr     (clr_src),
    .step    (byte_stb),
    .size    (src_span),
    .ptr_r   (src_progress),
    .done_r  (src_done),
    .half_r  (src_half)
  );

  progress_counter #(.CNT_W(CNT_W)) u_dst (
    .sys_clk (sys_clk),
    .rst_n   (rst_sync_n),
    .clr     (clr_all),
    .step    (byte_stb),
    .size    (dst_span),
    .ptr_r   (dst_progress),
    .done_r  (dst_done),
    .half_r  (dst_half)
  );

  progress_counter #(.CNT_W(CNT_W)) u_cell (
    .sys_clk (sys_clk),
    .rst_n   (rst_sync_n),
    .clr     (clr_src),
    .step    (byte_stb),
    .size    (cell_span),
    .ptr_r   (cell_progress),
    .done_r  (cell_done),
    .half_r  ()
  );

  // Block counter is internal only, its pointer is not visible
  progress_counter #(.CNT_W(CNT_W)) u_blk (
    .sys_clk (sys_clk),
    .rst_n   (rst_sync_n),
    .clr     (clr_all),
    .step    (byte_stb),
    .size    (blk_span),
    .ptr_r   (),
    .done_r  (blk_done),
    .half_r  ()
  );

  // Event vector in flag bit order
  wire [7:0] ev;
  assign ev[`EV_SRC_DONE]   = src_done;
  assign ev[`EV_SRC_HALF]   = src_half;
  assign ev[`EV_DST_DONE]   = dst_done;
  assign ev[`EV_DST_HALF]   = dst_half;
  assign ev[`EV_BLOCK_DONE] = blk_done | pattern_hit;
  assign ev[`EV_CELL_DONE]  = cell_done;
  assign ev[`EV_ABORT]      = abort_hit;
  assign ev[`EV_ADDR_ERR]   = src_addr_bad | dst_addr_bad;

  // Per-flag next state; an event in the clearing cycle is kept
  wire [7:0] irq_vec;
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_flag
      // A zero written clears the bit, a one leaves it alone
      wire zero_wr = int_wr & ~pwdata[`INT_FLAG_LSB + gi];
      assign flag_nxt[gi] = ev[gi] | (flag_r[gi] & ~zero_wr);
      // Enable gates only the request, never the flag itself
      assign irq_vec[gi]  = flag_r[gi] & irq_en_r[gi];
    end
  endgenerate

  always @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      flag_r <= `RST_BYTE;
    end else begin
      flag_r <= flag_nxt;
    end
  end

  assign chan_irq = |irq_vec;

  // Abort notice to the engine, one cycle after the source fires
  always @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      xfer_abort <= 1'b0;
    end else begin
      xfer_abort <= abort_hit;
    end
  end

  // Register writes, taken only in the access phase
  always @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      irq_en_r         <= `RST_BYTE;
      src_start        <= `RST_WORD;
      dst_start        <= `RST_WORD;
      src_size_r       <= `RST_HALF;
      dst_size_r       <= `RST_HALF;
      cell_size_r      <= `RST_HALF;
      abort_irq_select <= {SEL_W{1'b0}};
      abort_src_en_r   <= 1'b0;
    end else if (wr_commit) begin
      case (paddr)
        `OFS_INT_CTRL:  irq_en_r <= pwdata[`INT_EN_LSB +: 8];
        `OFS_SRC_START: src_start <= pwdata;
        `OFS_DST_START: dst_start <= pwdata;
        `OFS_SRC_SIZE:  src_size_r <= pwdata[CNT_W-1:0];
        `OFS_DST_SIZE:  dst_size_r <= pwdata[CNT_W-1:0];
        `OFS_CELL_SIZE: cell_size_r <= pwdata[CNT_W-1:0];
        `OFS_ABORT_CFG: begin
          abort_irq_select <= pwdata[`ABORT_SEL_LSB +: SEL_W];
          abort_src_en_r   <= pwdata[`ABORT_EN_BIT];
        end
        // Pointer registers ignore writes
        default: abort_src_en_r <= abort_src_en_r;
      endcase
    end
  end

  // Read mux; unused bits read zero
  reg [31:0] rd_mux;
  always @* begin
    rd_mux = 32'h0000_0000;
    case (paddr)
      `OFS_INT_CTRL: begin
        rd_mux[`INT_EN_LSB +: 8]   = irq_en_r;
        rd_mux[`INT_FLAG_LSB +: 8] = flag_r;
      end
      `OFS_SRC_START: rd_mux = src_start;
      `OFS_DST_START: rd_mux = dst_start;
      `OFS_SRC_SIZE:  rd_mux[CNT_W-1:0] = src_size_r;
      `OFS_DST_SIZE:  rd_mux[CNT_W-1:0] = dst_size_r;
      `OFS_SRC_PROG:  rd_mux[CNT_W-1:0] = src_progress;
      `OFS_DST_PROG:  rd_mux[CNT_W-1:0] = dst_progress;
      `OFS_CELL_SIZE: rd_mux[CNT_W-1:0] = cell_size_r;
      `OFS_ABORT_CFG: begin
        rd_mux[`ABORT_SEL_LSB +: SEL_W] = abort_irq_select;
        rd_mux[`ABORT_EN_BIT]           = abort_src_en_r;
      end
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // Read data and error captured at setup, so both stand from a flop
  // Trade-off: pointers are sampled one cycle before the access edge
  always @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      prdata  <= `RST_WORD;
      pslverr <= 1'b0;
    end else if (setup_ph) begin
      prdata  <= pwrite ? 32'h0000_0000 : rd_mux;
      pslverr <= ~map_hit(paddr);
    end
  end

endmodule // dma_chan_status

// ==== dma_chan_regs.vh ====
`ifndef DMA_CHAN_REGS_VH
`define DMA_CHAN_REGS_VH

// Register byte offsets, one aligned 32-bit word each
`define OFS_INT_CTRL   8'h00
`define OFS_SRC_START  8'h04
`define OFS_DST_START  8'h08
`define OFS_SRC_SIZE   8'h0c
`define OFS_DST_SIZE   8'h10
`define OFS_SRC_PROG   8'h14
`define OFS_DST_PROG   8'h18
`define OFS_CELL_SIZE  8'h1c
`define OFS_ABORT_CFG  8'h20

// Interrupt control layout: flags low byte, enables third byte
`define INT_FLAG_LSB   0
`define INT_EN_LSB     16
`define EV_SRC_DONE    7
`define EV_SRC_HALF    6
`define EV_DST_DONE    5
`define EV_DST_HALF    4
`define EV_BLOCK_DONE  3
`define EV_CELL_DONE   2
`define EV_ABORT       1
`define EV_ADDR_ERR    0

// Abort configuration layout
`define ABORT_SEL_LSB  8
`define ABORT_EN_BIT   0

// Reset values
`define RST_WORD       32'h0000_0000
`define RST_BYTE       8'h00
`define RST_HALF       16'h0000

`endif

// ==== progress_counter.v ====
`timescale 1ns/100ps
// Byte pointer that wraps at a programmed size and reports done and midpoint
module progress_counter #(
  parameter CNT_W = 16
) (
  input  wire             sys_clk,
  input  wire             rst_n,
  input  wire             clr,
  input  wire             step,
  input  wire [CNT_W:0]   size,
  output reg  [CNT_W-1:0] ptr_r,
  output reg              done_r,
  output reg              half_r
);

  wire [CNT_W:0] ptr_inc = {1'b0, ptr_r} + {{CNT_W{1'b0}}, 1'b1};
  wire [CNT_W:0] mid     = size >> 1;

  // Clear beats a step in the same cycle, the pointer restarts either way
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ptr_r  <= {CNT_W{1'b0}};
      done_r <= 1'b0;
      half_r <= 1'b0;
    end else begin
      done_r <= 1'b0;
      half_r <= 1'b0;
      if (clr) begin
        ptr_r <= {CNT_W{1'b0}};
      end else if (step) begin
        // Size of one has no midpoint, so mid of zero never matches
        half_r <= (ptr_inc == mid);
        if (ptr_inc == size) begin
          ptr_r  <= {CNT_W{1'b0}};
          done_r <= 1'b1;
        end else begin
          ptr_r <= ptr_inc[CNT_W-1:0];
        end
      end
    end
  end

endmodule // progress_counter

// ==== engine_model.sv ====
`timescale 1ns/100ps
// Far-side mover: one byte strobe a cycle while bytes are owed
module engine_model (
  input  wire       sys_clk,
  input  wire       rst_n,
  input  wire       go,
  input  wire [7:0] n_bytes,
  output reg        byte_stb,
  output wire       busy
);
  reg [7:0] left_r;
  assign busy = (left_r != 8'h00) || byte_stb;
  // Back-to-back strobes, the harshest legal pacing
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      left_r   <= 8'h00;
      byte_stb <= 1'b0;
    end else begin
      byte_stb <= (left_r != 8'h00);
      left_r   <= go ? n_bytes : left_r - {7'h00, left_r != 8'h00};
    end
  end
endmodule // engine_model

// ==== dma_chan_checker_properties.sv ====
`timescale 1ns/100ps
`include "dma_chan_regs.vh"
module dma_chan_checker #(
  parameter CNT_W = 16
) (
  input wire             sys_clk,
  input wire             rst_n,
  input wire             psel,
  input wire             penable,
  input wire             pwrite,
  input wire [7:0]       paddr,
  input wire [31:0]      pwdata,
  input wire [31:0]      prdata,
  input wire             byte_stb,
  input wire             pattern_hit,
  input wire             src_addr_bad,
  input wire             dst_addr_bad,
  input wire             chan_active,
  input wire             xfer_abort,
  input wire [31:0]      src_start,
  input wire [CNT_W-1:0] src_progress,
  input wire             chan_irq
);
  // Access and setup phases of the bus
  wire wr_hit = psel && penable && pwrite;
  wire rd_set = psel && !penable && !pwrite;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  a_start_load: assert property (wr_hit && paddr == `OFS_SRC_START |=> src_start == $past(pwdata))
    else $error("source start not loaded");
  a_int_zero: assert property (rd_set && paddr == `OFS_INT_CTRL |=> prdata[31:24] == 8'h00 && prdata[15:8] == 8'h00)
    else $error("unused control bytes not zero");
  a_size_upper: assert property (rd_set && (paddr == `OFS_SRC_SIZE || paddr == `OFS_DST_SIZE)
    |=> prdata[31:16] == 16'h0000)
    else $error("size upper half not zero");
  a_irq_rise: assert property ($rose(chan_irq) |-> $past(wr_hit) || $past(byte_stb)
    || $past(byte_stb, 2) || $past(byte_stb, 3) || $past(pattern_hit) || $past(src_addr_bad) || $past(dst_addr_bad)
    || xfer_abort)
    else $error("interrupt rose without cause");
  a_irq_fall: assert property ($fell(chan_irq) |-> $past(wr_hit && paddr == `OFS_INT_CTRL))
    else $error("interrupt fell without control write");
  a_abort_gate: assert property (xfer_abort |-> $past(chan_active))
    else $error("abort taken while channel idle");
  a_ptr_step: assert property ($past(byte_stb) && !$past(pattern_hit) && src_progress != 0
    |-> src_progress == $past(src_progress) + 1'b1)
    else $error("source pointer did not step by one");
  a_ptr_hold: assert property (!$past(byte_stb) && !$past(byte_stb, 2) && !$past(byte_stb, 3)
    && !$past(pattern_hit) && !xfer_abort && !$past(xfer_abort) |-> $stable(src_progress))
    else $error("source pointer moved on its own");
endmodule // dma_chan_checker

bind dma_chan_status dma_chan_checker #(.CNT_W(CNT_W)) u_chk (
  .sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .byte_stb(byte_stb), .pattern_hit(pattern_hit),
  .src_addr_bad(src_addr_bad), .dst_addr_bad(dst_addr_bad), .chan_active(chan_active),
  .xfer_abort(xfer_abort), .src_start(src_start), .src_progress(src_progress), .chan_irq(chan_irq)
);

// ==== dma_channel_status_and_sizing_tb_top.sv ====
`timescale 1ns/100ps
`include "dma_chan_regs.vh"
module dma_channel_status_and_sizing_tb_top;
  logic         sys_clk = 1'b0;
  logic         rst_n = 1'b0;
  logic         psel = 1'b0;
  logic         penable = 1'b0;
  logic         pwrite = 1'b0;
  logic [7:0]   paddr = 8'h00;
  logic [31:0]  pwdata = 32'h0;
  logic         pattern_hit = 1'b0;
  logic         src_addr_bad = 1'b0;
  logic         dst_addr_bad = 1'b0;
  logic         chan_active = 1'b0;
  logic [255:0] irq_lines = 256'h0;
  logic         go = 1'b0;
  logic [7:0]   n_bytes = 8'h00;
  logic [31:0]  rdq;
  logic         errq;
  wire          pready, pslverr, byte_stb, busy, xfer_abort, chan_irq;
  wire [31:0]   prdata, src_start, dst_start;
  wire [15:0]   src_progress, dst_progress, cell_progress;
  int           err_total = 0;
  int           comparisons = 0;
  typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] e;} row_t;
  // Address, write value, expected read-back
  row_t rows [7] = '{
    '{8'h04, 32'hffffffff, 32'hffffffff},
    '{8'h08, 32'h89abcdef, 32'h89abcdef},
    '{8'h0c, 32'hffff1234, 32'h00001234},
    '{8'h10, 32'hffffabcd, 32'h0000abcd},
    '{8'h00, 32'hffffffff, 32'h00ff0000},
    '{8'h14, 32'h0000ffff, 32'h00000000},
    '{8'h24, 32'hffffffff, 32'h00000000}};
  always #50 sys_clk = ~sys_clk;
  dma_chan_status u_dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .byte_stb(byte_stb), .pattern_hit(pattern_hit), .src_addr_bad(src_addr_bad),
    .dst_addr_bad(dst_addr_bad), .chan_active(chan_active), .irq_lines(irq_lines),
    .xfer_abort(xfer_abort), .src_start(src_start), .dst_start(dst_start),
    .src_progress(src_progress), .dst_progress(dst_progress), .cell_progress(cell_progress),
    .chan_irq(chan_irq));
  engine_model u_eng (.sys_clk(sys_clk), .rst_n(rst_n), .go(go), .n_bytes(n_bytes),
    .byte_stb(byte_stb), .busy(busy));
  // One bus transfer, held until pready is seen
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1) @(posedge sys_clk);
    rdq = prdata;
    errq = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Ask the far side for a burst, then let flags land
  task automatic bytes(input logic [7:0] n);
    @(posedge sys_clk);
    go <= 1'b1;
    n_bytes <= n;
    @(posedge sys_clk);
    go <= 1'b0;
    @(posedge sys_clk);
    while (busy) @(posedge sys_clk);
    repeat (3) @(posedge sys_clk);
  endtask
  task automatic give_verdict();
    $display("comparisons=%0d mismatches=%0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Watchdog, far beyond the 150 or so cycles needed
  initial begin
    #500000;
    err_total++;
    give_verdict();
  end
  initial begin
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    foreach (rows[i]) begin
      apb(0, rows[i].a, 0);
      chk(rdq, 32'h0);
      apb(1, rows[i].a, rows[i].d);
      apb(0, rows[i].a, 0);
      chk(rdq, rows[i].e);
      chk({31'h0, errq}, {31'h0, rows[i].a > 8'h20});
    end
    chk(src_start, 32'hffffffff);
    chk(dst_start, 32'h89abcdef);
    $display("register rows done");
    apb(1, `OFS_SRC_SIZE, 32'h4);
    apb(1, `OFS_DST_SIZE, 32'h2);
    bytes(8'h02);
    apb(0, `OFS_INT_CTRL, 0);
    chk(rdq, 32'h00ff0070);
    chk({16'h0, cell_progress}, 32'h2);
    chk({31'h0, chan_irq}, 32'h1);
    apb(1, `OFS_INT_CTRL, 32'h70);
    bytes(8'h02);
    apb(0, `OFS_INT_CTRL, 0);
    chk(rdq, 32'h000000f8);
    chk({31'h0, chan_irq}, 32'h0);
    chk({16'h0, src_progress}, 32'h0);
    $display("size flag test done");
    apb(1, `OFS_INT_CTRL, 32'h00ff0000);
    apb(1, `OFS_ABORT_CFG, 32'h0501);
    bytes(8'h01);
    @(posedge sys_clk);
    pattern_hit <= 1'b1;
    src_addr_bad <= 1'b1;
    irq_lines[5] <= 1'b1;
    @(posedge sys_clk);
    pattern_hit <= 1'b0;
    src_addr_bad <= 1'b0;
    irq_lines[5] <= 1'b0;
    apb(0, `OFS_INT_CTRL, 0);
    chk(rdq, 32'h00ff0019);
    chk({16'h0, src_progress}, 32'h0);
    chk({16'h0, dst_progress}, 32'h1);
    chan_active <= 1'b1;
    irq_lines[5] <= 1'b1;
    dst_addr_bad <= 1'b1;
    @(posedge sys_clk);
    irq_lines[5] <= 1'b0;
    dst_addr_bad <= 1'b0;
    chan_active <= 1'b0;
    @(negedge sys_clk);
    chk({31'h0, xfer_abort}, 32'h1);
    apb(0, `OFS_INT_CTRL, 0);
    chk(rdq, 32'h00ff001b);
    chk({31'h0, chan_irq}, 32'h1);
    $display("event test done");
    apb(1, `OFS_CELL_SIZE, 32'h3);
    apb(1, `OFS_INT_CTRL, 32'h00ff0000);
    bytes(8'h03);
    apb(0, `OFS_INT_CTRL, 0);
    chk(rdq & 32'h4, 32'h4);
    $display("cell test done");
    @(posedge sys_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    apb(0, `OFS_INT_CTRL, 0);
    chk(rdq, 32'h0);
    chk({31'h0, chan_irq}, 32'h0);
    $display("reset test done");
    give_verdict();
  end
endmodule // dma_channel_status_and_sizing_tb_top
